//--- core/mlc_cfg_mem.sv
// Element configuration store: one word per element, address in low byte, type in high.
`timescale 1ns/1ps
`include "mlc_params.svh"
module mlc_cfg_mem (
  input wire logic hclk,     // System clock.
  input wire logic hresetn,  // Asynchronous reset, active low.
  mlc_mem_if.mem   port      // Write and registered read port.
);
  logic [`MLC_NUM_ELEM-1:0][15:0] mem_reg;
  logic [15:0]                    rdata_reg;

  // Cleared at reset so every element starts undefined.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_reg   <= '0;
      rdata_reg <= 16'h0000;
    end else begin
      if (port.we[0]) begin
        mem_reg[port.widx][7:0] <= port.wdata[7:0];
      end
      if (port.we[1]) begin
        mem_reg[port.widx][15:8] <= port.wdata[15:8];
      end
      rdata_reg <= mem_reg[port.ridx];
    end
  end

  assign port.rdata = rdata_reg;
endmodule

//--- core/mlc_edge_unit.sv
// One local input: edge detection and pending primary/secondary message requests.
`timescale 1ns/1ps
`include "mlc_params.svh"
module mlc_edge_unit (
  input  wire logic       hclk,     // System clock.
  input  wire logic       hresetn,  // Asynchronous reset, active low.
  input  wire logic       level,    // Input pin level.
  input  wire logic [3:0] trans,    // Transition selection value, low nibble.
  input  wire logic       pri_en,   // Primary address is nonzero.
  input  wire logic       sec_en,   // Secondary address is nonzero.
  input  wire logic [1:0] inv,      // Invert selection, secondary in bit 1.
  input  wire logic [1:0] ack,      // Request taken, secondary in bit 1.
  output logic      [1:0] pend,     // Pending request, secondary in bit 1.
  output logic      [1:0] pst       // State to send, secondary in bit 1.
);
  mlc_pkg::mlc_edge_s q, n;
  logic rise, fall;

  always_comb begin
    n = q;
    rise     = q.primed & level & ~q.prev;
    fall     = q.primed & ~level & q.prev;
    n.prev   = level;
    n.primed = 1'b1;
    n.pend   = q.pend & ~ack;
    if (pri_en && ((rise && trans[`MLC_TR_PRI_RISE]) || (fall && trans[`MLC_TR_PRI_FALL]))) begin
      n.pend[0] = 1'b1;
      n.pst[0]  = level ^ inv[0];
    end
    if (sec_en && ((rise && trans[`MLC_TR_SEC_RISE]) || (fall && trans[`MLC_TR_SEC_FALL]))) begin
      n.pend[1] = 1'b1;
      n.pst[1]  = level ^ inv[1];
    end
  end

  // The first cycle after reset only samples the level, so a high pin is no edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign pend = q.pend;
  assign pst  = q.pst;
endmodule

//--- core/mlc_mem_if.sv
// Port group between the cell controller and the element configuration store.
`timescale 1ns/1ps
interface mlc_mem_if;
  logic [1:0]  we;
  logic [3:0]  widx;
  logic [15:0] wdata;
  logic [3:0]  ridx;
  logic [15:0] rdata;
  modport ctrl (output we, widx, wdata, ridx, input rdata);
  modport mem  (input we, widx, wdata, ridx, output rdata);
endinterface

//--- core/mlc_params.svh
// Constants for the message logic cell block: sizes, register map, field positions.
`ifndef MLC_PARAMS_SVH
`define MLC_PARAMS_SVH
`define MLC_NUM_CELLS      4
`define MLC_NUM_ELEM       12
`define MLC_ELEM_PER_CELL  3
`define MLC_NUM_IN         4
`define MLC_IN_REGS        5
`define MLC_NUM_IN_CFG     20
`define MLC_NUM_CELL_REGS  24
`define MLC_AW             12
`define MLC_REG_CELL       4'h0
`define MLC_REG_INPUT      4'h1
`define MLC_REG_STATUS     12'h200
`define MLC_IN_PRI_ADDR    0
`define MLC_IN_PRI_TYPE    1
`define MLC_IN_SEC_ADDR    3
`define MLC_IN_SEC_TYPE    4
`define MLC_IN_TRANS       2
`define MLC_TYPE_LOGIC_BIT 7
`define MLC_TYPE_INV_BIT   7
`define MLC_TYPE_STATE_BIT 6
`define MLC_TYPE_SENS_BIT  5
`define MLC_TYPE_FDBK_BIT  4
`define MLC_ADDER_MAX      4'h9
`define MLC_TR_PRI_RISE    0
`define MLC_TR_PRI_FALL    1
`define MLC_TR_SEC_RISE    2
`define MLC_TR_SEC_FALL    3
`define MLC_ST_CELL_LSB    16
`define MLC_ST_BUSY_BIT    20
`define MLC_ADDER_TABLE    {12'h900, 12'h800, 12'h700, 12'h600, 12'h500, \
                            12'h400, 12'h300, 12'h200, 12'h100, 12'h000}
`define MLC_HRESP_OKAY     1'b0
`endif

//--- core/mlc_pkg.sv
// Types shared by the message logic cell modules.
`include "mlc_params.svh"
package mlc_pkg;
  typedef enum logic [1:0] {
    MLC_KIND_SWITCH = 2'h0,
    MLC_KIND_FDBK   = 2'h1,
    MLC_KIND_SENSOR = 2'h2
  } mlc_kind_e;
  typedef enum logic [1:0] {
    MLC_SCAN_IDLE  = 2'h0,
    MLC_SCAN_ISSUE = 2'h1,
    MLC_SCAN_EVAL  = 2'h3
  } mlc_scan_e;
  typedef struct packed {
    logic [1:0] pend;
    logic [1:0] pst;
    logic       prev;
    logic       primed;
  } mlc_edge_s;
  typedef struct packed {
    logic hready; logic hresp; logic [31:0] hrdata;
    logic wr_pend; logic rd_pend; logic [11:0] dp_addr;
    logic [`MLC_NUM_ELEM-1:0] el_state; logic [`MLC_NUM_ELEM-1:0] addr_nz;
    logic [`MLC_NUM_ELEM-1:0] logic_and; logic [`MLC_NUM_CELLS-1:0] cell_out;
    mlc_scan_e scan_st; logic [3:0] scan_idx;
    logic [`MLC_AW-1:0] msg_addr; mlc_kind_e msg_kind; logic msg_state; logic rx_ready;
    logic [`MLC_NUM_IN_CFG-1:0][7:0] in_cfg;
    logic tx_valid; logic [`MLC_AW-1:0] tx_addr; mlc_kind_e tx_kind; logic tx_state;
    logic [2:0] tx_src;
  } mlc_top_s;
endpackage

//--- core/mlc_top.sv
// Message logic cell evaluator and input message generator with an AHB-Lite register slave.
// What this block does
// - Each cell has six configuration values.
// - Matching address, type, state sets element true.
// - Opposite state message clears a true element.
// - Zero address with OR logic is ignored.
// - Only A defined, B and C logic bits on OR: cell follows A.
// - Zero address with AND logic stays false.
// - B and C logic bits pick function.
// - Cell output follows its combination result.
// - Element address value spans 1 to 255.
// - Type decodes state, message type, adder.
// - Adder value 0 to 9 extends address.
// - Each input has primary and secondary messages.
// - Transition value picks messages and edges.
// - Invert selection sends true on low input.
// - High-to-low is falling, low-to-high rising.
`timescale 1ns/1ps
`include "mlc_params.svh"
module mlc_top (
  input  wire logic                    hclk,       // System clock, 100 MHz.
  input  wire logic                    hresetn,    // Asynchronous reset, active low.
  input  wire logic                    hsel,       // Slave select.
  input  wire logic [31:0]             haddr,      // Byte address.
  input  wire logic [1:0]              htrans,     // Transfer type.
  input  wire logic                    hwrite,     // Write when high.
  input  wire logic [2:0]              hsize,      // Word transfers only.
  input  wire logic [31:0]             hwdata,     // Write data.
  input  wire logic                    hready,     // Bus ready.
  output logic      [31:0]             hrdata,     // Read data.
  output logic                         hreadyout,  // Slave ready.
  output logic                         hresp,      // Always OKAY.
  input  wire logic                    rx_valid,   // Received bus message present.
  input  wire logic [`MLC_AW-1:0]      rx_addr,    // Received message address.
  input  wire logic [1:0]              rx_kind,    // Received message type.
  input  wire logic                    rx_state,   // Received message state.
  output logic                         rx_ready,   // Message taken.
  input  wire logic [`MLC_NUM_IN-1:0]  in_level,   // Local input levels.
  output logic                         tx_valid,   // Outgoing message present.
  output logic      [`MLC_AW-1:0]      tx_addr,    // Outgoing message address.
  output logic      [1:0]              tx_kind,    // Outgoing message type.
  output logic                         tx_state,   // Outgoing message state.
  input  wire logic                    tx_ready,   // Outgoing message taken.
  output logic      [`MLC_NUM_CELLS-1:0] cell_out  // Logic cell outputs.
);
  localparam logic [9:0][`MLC_AW-1:0] ADDER_TABLE = `MLC_ADDER_TABLE;
  localparam logic [3:0] LAST_ELEM = 4'hB;

  mlc_pkg::mlc_top_s q, n;
  mlc_mem_if         mem_bus ();
  logic [2*`MLC_NUM_IN-1:0] pend, pst, ack;
  logic              addr_ph, bus_rd, found;
  logic [7:0]        ty, ad;
  logic [31:0]       rd_word;
  logic              ab;
  int                base;

  function automatic mlc_pkg::mlc_kind_e kind_of(input logic [7:0] t);
    if (t[`MLC_TYPE_SENS_BIT]) begin
      return mlc_pkg::MLC_KIND_SENSOR;
    end else if (t[`MLC_TYPE_FDBK_BIT]) begin
      return mlc_pkg::MLC_KIND_FDBK;
    end
    return mlc_pkg::MLC_KIND_SWITCH;
  endfunction

  // address extended by adder; out-of-range adder values add nothing.
  function automatic logic [`MLC_AW-1:0] eff_addr(input logic [7:0] a, input logic [7:0] t);
    logic [`MLC_AW-1:0] wide;
    wide = {4'h0, a};
    if (t[3:0] <= `MLC_ADDER_MAX) begin
      return wide + ADDER_TABLE[t[3:0]];
    end
    return wide;
  endfunction

  mlc_cfg_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .port    (mem_bus.mem)
  );

  // one primary and one secondary request per input
  genvar gi;
  generate
    for (gi = 0; gi < `MLC_NUM_IN; gi++) begin : g_in
      mlc_edge_unit u_edge (
        .hclk    (hclk),
        .hresetn (hresetn),
        .level   (in_level[gi]),
        .trans   (q.in_cfg[gi*`MLC_IN_REGS+`MLC_IN_TRANS][3:0]),
        .pri_en  (q.in_cfg[gi*`MLC_IN_REGS+`MLC_IN_PRI_ADDR] != 8'h00),
        .sec_en  (q.in_cfg[gi*`MLC_IN_REGS+`MLC_IN_SEC_ADDR] != 8'h00),
        .inv     ({q.in_cfg[gi*`MLC_IN_REGS+`MLC_IN_SEC_TYPE][`MLC_TYPE_INV_BIT],
                   q.in_cfg[gi*`MLC_IN_REGS+`MLC_IN_PRI_TYPE][`MLC_TYPE_INV_BIT]}),
        .ack     (ack[2*gi+1:2*gi]),
        .pend    (pend[2*gi+1:2*gi]),
        .pst     (pst[2*gi+1:2*gi])
      );
    end
  endgenerate

  // Read data for the word whose address phase was taken last cycle.
  always_comb begin
    rd_word = 32'h0000_0000;
    if (q.dp_addr[11:8] == `MLC_REG_CELL && q.dp_addr[7:2] < 6'(`MLC_NUM_CELL_REGS)) begin
      rd_word[7:0] = q.dp_addr[2] ? mem_bus.rdata[15:8] : mem_bus.rdata[7:0];
    end else if (q.dp_addr[11:8] == `MLC_REG_INPUT && q.dp_addr[7:2] < 6'(`MLC_NUM_IN_CFG)) begin
      rd_word[7:0] = q.in_cfg[q.dp_addr[6:2]];
    end else if (q.dp_addr == `MLC_REG_STATUS) begin
      rd_word[`MLC_NUM_ELEM-1:0] = q.el_state;
      rd_word[`MLC_ST_CELL_LSB +: `MLC_NUM_CELLS] = q.cell_out;
      rd_word[`MLC_ST_BUSY_BIT] = (q.scan_st != mlc_pkg::MLC_SCAN_IDLE);
    end
  end

  always_comb begin
    n             = q;
    ack           = '0;
    found         = 1'b0;
    base          = 0;
    ty            = mem_bus.rdata[15:8];
    ad            = mem_bus.rdata[7:0];
    ab            = 1'b0;
    addr_ph       = hsel & hready & htrans[1];
    bus_rd        = addr_ph & ~hwrite;
    mem_bus.we    = 2'b00;
    mem_bus.widx  = q.dp_addr[6:3];
    mem_bus.wdata = {hwdata[7:0], hwdata[7:0]};
    mem_bus.ridx  = bus_rd ? haddr[6:3] : q.scan_idx;
    n.hresp       = `MLC_HRESP_OKAY;

    // Reads take one wait state because cell configuration sits in the store.
    n.wr_pend = addr_ph & hwrite;
    n.rd_pend = bus_rd;
    if (addr_ph) begin
      n.dp_addr = haddr[11:0];
    end
    if (bus_rd) begin
      n.hready = 1'b0;
    end
    if (q.rd_pend) begin
      n.hready = 1'b1;
      n.hrdata = rd_word;
    end

    // Scanner walks all elements, one store read per element.
    case (q.scan_st)
      mlc_pkg::MLC_SCAN_IDLE: begin
        if (rx_valid && q.rx_ready) begin
          n.msg_addr  = rx_addr;
          n.msg_kind  = mlc_pkg::mlc_kind_e'(rx_kind);
          n.msg_state = rx_state;
          n.rx_ready  = 1'b0;
          n.scan_idx  = 4'h0;
          n.scan_st   = mlc_pkg::MLC_SCAN_ISSUE;
        end
      end
      mlc_pkg::MLC_SCAN_ISSUE: begin
        if (!bus_rd) begin
          n.scan_st = mlc_pkg::MLC_SCAN_EVAL;
        end
      end
      mlc_pkg::MLC_SCAN_EVAL: begin
        if (ad != 8'h00 && eff_addr(ad, ty) == q.msg_addr && kind_of(ty) == q.msg_kind) begin
          n.el_state[q.scan_idx] = (q.msg_state == ty[`MLC_TYPE_STATE_BIT]);
        end
        if (q.scan_idx == LAST_ELEM) begin
          n.scan_st  = mlc_pkg::MLC_SCAN_IDLE;
          n.rx_ready = 1'b1;
        end else begin
          n.scan_idx = q.scan_idx + 4'h1;
          n.scan_st  = mlc_pkg::MLC_SCAN_ISSUE;
        end
      end
      default: begin
        n.scan_st  = mlc_pkg::MLC_SCAN_IDLE;
        n.rx_ready = 1'b1;
      end
    endcase

    // two values per element, six per cell
    if (q.wr_pend) begin
      if (q.dp_addr[11:8] == `MLC_REG_CELL && q.dp_addr[7:2] < 6'(`MLC_NUM_CELL_REGS)) begin
        mem_bus.we = q.dp_addr[2] ? 2'b10 : 2'b01;
        if (q.dp_addr[2]) begin
          n.logic_and[q.dp_addr[6:3]] = hwdata[`MLC_TYPE_LOGIC_BIT];
        end else begin
          n.addr_nz[q.dp_addr[6:3]] = (hwdata[7:0] != 8'h00);
          if (hwdata[7:0] == 8'h00) begin
            n.el_state[q.dp_addr[6:3]] = 1'b0;
          end
        end
      end else if (q.dp_addr[11:8] == `MLC_REG_INPUT && q.dp_addr[7:2] < 6'(`MLC_NUM_IN_CFG)) begin
        n.in_cfg[q.dp_addr[6:2]] = hwdata[7:0];
      end
    end

    for (int c = 0; c < `MLC_NUM_CELLS; c++) begin
      ab = q.logic_and[3*c+1] ? (q.el_state[3*c] & q.el_state[3*c+1])
                              : (q.el_state[3*c] | q.el_state[3*c+1]);
      n.cell_out[c] = q.logic_and[3*c+2] ? (ab & q.el_state[3*c+2]) : (ab | q.el_state[3*c+2]);
    end

    // Outgoing message stands until taken; lowest pending request goes next.
    if (!q.tx_valid || tx_ready) begin
      n.tx_valid = 1'b0;
      for (int j = 0; j < 2*`MLC_NUM_IN; j++) begin
        if (!found && pend[j]) begin
          found      = 1'b1;
          ack[j]     = 1'b1;
          base       = (j / 2) * `MLC_IN_REGS + ((j % 2) != 0 ? `MLC_IN_SEC_ADDR : 0);
          n.tx_valid = 1'b1;
          n.tx_addr  = eff_addr(q.in_cfg[base], q.in_cfg[base+1]);
          n.tx_kind  = kind_of(q.in_cfg[base+1]);
          n.tx_state = pst[j];
          n.tx_src   = 3'(j);
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.hready   <= 1'b1;
      q.rx_ready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign hrdata    = q.hrdata;
  assign hreadyout = q.hready;
  assign hresp     = q.hresp;
  assign rx_ready  = q.rx_ready;
  assign tx_valid  = q.tx_valid;
  assign tx_addr   = q.tx_addr;
  assign tx_kind   = q.tx_kind;
  assign tx_state  = q.tx_state;
  assign cell_out  = q.cell_out;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_eval_hit;
    q.scan_st == mlc_pkg::MLC_SCAN_EVAL && ad != 8'h00 &&
      eff_addr(ad, ty) == q.msg_addr && kind_of(ty) == q.msg_kind && !q.wr_pend;
  endsequence

  chk_elem_set: assert property (s_eval_hit and (q.msg_state == ty[`MLC_TYPE_STATE_BIT])
    |=> q.el_state[$past(q.scan_idx)]) else $error("matching element not set");
  chk_elem_clear: assert property (s_eval_hit and (q.msg_state != ty[`MLC_TYPE_STATE_BIT])
    |=> !q.el_state[$past(q.scan_idx)]) else $error("opposite state did not clear");
  chk_zero_false: assert property ((q.el_state & ~q.addr_nz) == '0)
    else $error("zero-address element is true");
  chk_lone_a: assert property ((q.addr_nz[2:1] == 2'b00 && q.logic_and[2:1] == 2'b00)
    |=> q.cell_out[0] == $past(q.el_state[0])) else $error("cell 0 not following A");
  chk_and_and: assert property ((q.logic_and[2:1] == 2'b11)
    |=> q.cell_out[0] == $past(&q.el_state[2:0])) else $error("AND/AND wrong");
  chk_scan_busy: assert property ((rx_valid && rx_ready) |=> !rx_ready [*8])
    else $error("ready returned too early");
  chk_read_wait: assert property ((hsel && hready && htrans[1] && !hwrite)
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  chk_tx_hold: assert property ((tx_valid && !tx_ready)
    |=> tx_valid && $stable(tx_addr) && $stable(tx_state)) else $error("tx dropped");
  chk_sec_zero: assert property ((tx_valid && q.tx_src[0])
    |-> q.in_cfg[(q.tx_src >> 1) * `MLC_IN_REGS + `MLC_IN_SEC_ADDR] != 8'h00)
    else $error("secondary sent with zero address");
endmodule

//--- testbench/mlc_bus_model.sv
// Far-side model of the layout message bus: offers received messages, takes outgoing ones.
`timescale 1ns/1ps
`include "mlc_params.svh"
module mlc_bus_model (
  input  wire logic               hclk,      // System clock.
  input  wire logic               hresetn,   // Reset, active low.
  output logic                    rx_valid,  // Message offered to the block.
  output logic      [`MLC_AW-1:0] rx_addr,   // Offered address.
  output logic      [1:0]         rx_kind,   // Offered message type.
  output logic                    rx_state,  // Offered state.
  input  wire logic               rx_ready,  // Block took the message.
  input  wire logic               tx_valid,  // Block offers a message.
  input  wire logic [`MLC_AW-1:0] tx_addr,   // Offered address.
  input  wire logic [1:0]         tx_kind,   // Offered message type.
  input  wire logic               tx_state,  // Offered state.
  output logic                    tx_ready   // Message taken.
);
  int          stall;
  int          wait_cnt;
  logic [14:0] got_q[$];

  initial begin
    stall = 2;
    rx_valid = 1'b0;
    rx_addr = 12'h000;
    rx_kind = 2'h0;
    rx_state = 1'b0;
  end

  // Released lines show the inverse of the last value, so a stale sample cannot match.
  task automatic send(input logic [11:0] a, input logic [1:0] k, input logic s);
    @(posedge hclk);
    rx_valid <= 1'b1;
    rx_addr  <= a;
    rx_kind  <= k;
    rx_state <= s;
    do @(posedge hclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_addr  <= ~a;
    rx_kind  <= ~k;
    rx_state <= ~s;
    do @(posedge hclk); while (rx_ready !== 1'b1);
  endtask

  // A slow taker: ready only after a set number of waiting cycles.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid && tx_ready) begin
      got_q.push_back({tx_addr, tx_kind, tx_state});
      tx_ready <= 1'b0;
      wait_cnt <= 0;
    end else if (tx_valid) begin
      if (wait_cnt >= stall) tx_ready <= 1'b1;
      else wait_cnt <= wait_cnt + 1;
    end
  end
endmodule

//--- testbench/test_message_logic_cell.sv
// Self-checking bench for the message logic cell block.
`timescale 1ns/1ps
`include "mlc_params.svh"
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
  end \
end
module test_message_logic_cell;
  logic                     hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]              haddr, hwdata, hrdata;
  logic [1:0]               htrans, rx_kind, tx_kind;
  logic [2:0]               hsize;
  logic                     rx_valid, rx_ready, rx_state, tx_valid, tx_ready, tx_state;
  logic [`MLC_AW-1:0]       rx_addr, tx_addr;
  logic [`MLC_NUM_IN-1:0]   in_level;
  logic [`MLC_NUM_CELLS-1:0] cell_out;
  int                       err_count;
  int                       comparisons;

  mlc_top mlc_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_valid(rx_valid),
    .rx_addr(rx_addr), .rx_kind(rx_kind), .rx_state(rx_state), .rx_ready(rx_ready),
    .in_level(in_level), .tx_valid(tx_valid), .tx_addr(tx_addr), .tx_kind(tx_kind),
    .tx_state(tx_state), .tx_ready(tx_ready), .cell_out(cell_out));
  mlc_bus_model mlc_bus_model_inst (.hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid),
    .rx_addr(rx_addr), .rx_kind(rx_kind), .rx_state(rx_state), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_addr(tx_addr), .tx_kind(tx_kind), .tx_state(tx_state),
    .tx_ready(tx_ready));

  always #5 hclk = ~hclk;

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    ahb(1'b1, a, d, unused);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    `CHK("register", e, v)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // Registered cell outputs need one more edge after the scan ends.
  task automatic settle();
    @(posedge hclk);
    #1;
  endtask

  function automatic logic f_cell(int c, logic a, logic b, logic x);
    case (c)
      0: return a | b | x;
      1: return (a | b) & x;
      2: return (a & b) | x;
      default: return a & b & x;
    endcase
  endfunction

  task automatic t_reset();
    `CHK("cell_out", 4'h0, cell_out)
    rd_chk(32'h200, 32'h0);
    wr(32'h05C, 32'h1FF);
    rd_chk(32'h05C, 32'hFF);
    wr(32'h060, 32'hFF);
    rd_chk(32'h060, 32'h0);
    wr(32'h05C, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_combos();
    logic [3:0] ex;
    for (int c = 0; c < 4; c++) begin
      wr(4 * (6 * c), 32'h0A);
      wr(4 * (6 * c + 1), 32'h40);
      wr(4 * (6 * c + 2), 32'h0B);
      wr(4 * (6 * c + 3), c[1] ? 32'hC0 : 32'h40);
      wr(4 * (6 * c + 4), 32'h0C);
      wr(4 * (6 * c + 5), c[0] ? 32'hC0 : 32'h40);
    end
    for (int p = 0; p < 8; p++) begin
      mlc_bus_model_inst.send(12'h00A, 2'h0, p[2]);
      mlc_bus_model_inst.send(12'h00B, 2'h0, p[1]);
      mlc_bus_model_inst.send(12'h00C, 2'h0, p[0]);
      for (int c = 0; c < 4; c++) ex[c] = f_cell(c, p[2], p[1], p[0]);
      settle();
      `CHK("cell_out", ex, cell_out)
      rd_chk(32'h200, {12'h0, ex, 4'h0, {4{p[0], p[1], p[2]}}});
    end
    $display("test combos done");
  endtask

  task automatic t_undef();
    wr(32'h08, 32'h0);
    wr(32'h10, 32'h0);
    wr(32'h50, 32'h0);
    mlc_bus_model_inst.send(12'h00A, 2'h0, 1'b0);
    settle();
    `CHK("cell_out", 4'b0110, cell_out)
    mlc_bus_model_inst.send(12'h00A, 2'h0, 1'b1);
    settle();
    `CHK("cell_out", 4'b0111, cell_out)
    $display("test undefined done");
  endtask

  task automatic t_kinds();
    logic [1:0] kc;
    for (int k = 0; k < 3; k++) begin
      kc = k[1:0];
      wr(32'h00, 32'h0);
      wr(32'h00, 32'h07);
      wr(32'h04, 32'h49 | (k == 2 ? 32'h20 : k == 1 ? 32'h10 : 32'h0));
      mlc_bus_model_inst.send(12'h907, k == 2 ? 2'h0 : kc + 2'h1, 1'b1);
      settle();
      `CHK("cell_a", 1'b0, cell_out[0])
      mlc_bus_model_inst.send(12'h007, kc, 1'b1);
      settle();
      `CHK("cell_a", 1'b0, cell_out[0])
      mlc_bus_model_inst.send(12'h907, kc, 1'b1);
      settle();
      `CHK("cell_a", 1'b1, cell_out[0])
      mlc_bus_model_inst.send(12'h907, kc, 1'b0);
      settle();
      `CHK("cell_a", 1'b0, cell_out[0])
    end
    $display("test kinds done");
  endtask

  task automatic t_transmit();
    wr(32'h100, 32'h01);
    wr(32'h104, 32'hA1);
    wr(32'h108, 32'h0B);
    wr(32'h10C, 32'h3C);
    wr(32'h110, 32'h00);
    wr(32'h11C, 32'h0F);
    wr(32'h128, 32'h2A);
    wr(32'h12C, 32'h20);
    wr(32'h130, 32'h01);
    mlc_bus_model_inst.stall = 0;
    @(posedge hclk);
    in_level <= 4'b1000;
    for (int i = 0; i < 200 && mlc_bus_model_inst.got_q.size() < 2; i++) @(posedge hclk);
    repeat (20) @(posedge hclk);
    `CHK("tx count", 2, mlc_bus_model_inst.got_q.size())
    `CHK("tx msg", 15'h080D, mlc_bus_model_inst.got_q.pop_front())
    `CHK("tx msg", 15'h01E0, mlc_bus_model_inst.got_q.pop_front())
    mlc_bus_model_inst.stall = 4;
    in_level <= 4'hF;
    for (int i = 0; i < 200 && mlc_bus_model_inst.got_q.size() < 2; i++) @(posedge hclk);
    repeat (20) @(posedge hclk);
    `CHK("tx count", 2, mlc_bus_model_inst.got_q.size())
    `CHK("tx msg", 15'h080C, mlc_bus_model_inst.got_q.pop_front())
    `CHK("tx msg", 15'h0155, mlc_bus_model_inst.got_q.pop_front())
    $display("test transmit done");
  endtask

  // The whole run needs under two thousand cycles; this limit leaves ample room.
  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    final_report();
  end

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    in_level = 4'hF;
    err_count = 0;
    comparisons = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_combos();
    t_undef();
    t_kinds();
    t_transmit();
    final_report();
  end
endmodule
